// ===== vcu_pkg.sv
// Constants and types for the vector compare unit
// Functional notes
// - Bounds code bit 1 is 0 when first element <= second, else 1.
// - Bounds code bit 0 is 0 when first element >= negated second, else 1.
// - Bounds code sits in each lane's two top bits; other lane bits zero.
// - Recorded bounds compare writes field six as 00, all-within flag, 0.
// - A negative second element makes the first element out of bounds.
// - A NaN in either bounds operand forces both code bits to 1.
// - With denormal flush set, denormal bounds operands become zero first.
// - Float equal sets a lane to all ones when elements are equal.
// - Float equal gives zero for any lane holding a NaN.
// - Float greater-or-equal sets a lane to ones when first >= second.
// - Float greater-or-equal gives zero for any lane holding a NaN.
// - Recorded equal/ge compares write all-true, 0, none-true, 0.
// - Without the record bit, condition field six stays unchanged.
// - Integer equal works on byte, halfword or word lanes, ones on match.
// - Integer equal is plain bitwise equality, sign does not matter.
// - Float compares decode from opcode 04 with endings 3C6, 0C6, 1C6.
// - Integer equal compares decode from endings 006, 046, 086.
package vcu_pkg;
   localparam int VCU_VEC_W = 128;
   localparam int VCU_LANE_W = 32;
   localparam int VCU_LANES = 4;
   localparam int VCU_BYTES = 16;
   localparam int VCU_REG_ADDR_W = 4;
   localparam int VCU_REG_DATA_W = 32;
   localparam logic [5:0] VCU_PRIMARY_OPCODE = 6'h04;
   localparam int VCU_OPCODE_MSB = 31;
   localparam int VCU_OPCODE_LSB = 26;
   localparam int VCU_RECORD_POS = 10;
   localparam logic [9:0] VCU_XO_BOUNDS = 10'h3C6;
   localparam logic [9:0] VCU_XO_FP_EQUAL = 10'h0C6;
   localparam logic [9:0] VCU_XO_FP_GE = 10'h1C6;
   localparam logic [9:0] VCU_XO_EQ_BYTE = 10'h006;
   localparam logic [9:0] VCU_XO_EQ_HALF = 10'h046;
   localparam logic [9:0] VCU_XO_EQ_WORD = 10'h086;
   localparam logic [7:0] VCU_EXP_ALL_ONES = 8'hFF;
   localparam logic [31:0] VCU_ZERO_KEY = 32'h8000_0000;
   localparam logic [3:0] VCU_CR_MASK_BOUNDS = 4'h2;
   localparam logic [3:0] VCU_CR_MASK_FULL = 4'hF;
   localparam logic [3:0] VCU_CR_RESET = 4'h0;
   localparam logic [3:0] VCU_CTRL_OFFSET = 4'h0;
   localparam logic [3:0] VCU_STATUS_OFFSET = 4'h4;
   localparam int VCU_FLUSH_BIT = 0;
   localparam logic VCU_FLUSH_RESET = 1'b0;
   localparam int VCU_STATUS_UNDECODED_BIT = 4;

   typedef enum logic [6:0] {
      VCU_OP_NONE = 7'h01,
      VCU_OP_BOUNDS = 7'h02,
      VCU_OP_FP_EQUAL = 7'h04,
      VCU_OP_FP_GE = 7'h08,
      VCU_OP_EQ_BYTE = 7'h10,
      VCU_OP_EQ_HALF = 7'h20,
      VCU_OP_EQ_WORD = 7'h40
   } vcu_op_type;
endpackage : vcu_pkg

// ===== vcu_compare_unit.sv
// Vector compare unit: decode, lane compares, result and condition registers
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module vcu_compare_unit
   import vcu_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic ISSUE_VALID,
   input wire logic [31:0] INSTRUCTION,
   input wire logic [VCU_VEC_W-1:0] FIRST_SOURCE_VECTOR,
   input wire logic [VCU_VEC_W-1:0] SECOND_SOURCE_VECTOR,
   input wire logic [VCU_REG_ADDR_W-1:0] REG_ADDRESS,
   input wire logic [VCU_REG_DATA_W-1:0] REG_WRITE_DATA,
   input wire logic REG_WRITE,
   input wire logic REG_READ,
   output var logic [VCU_REG_DATA_W-1:0] REG_READ_DATA,
   output var logic RESULT_VALID,
   output var logic [VCU_VEC_W-1:0] DESTINATION_VECTOR,
   output var logic [3:0] CONDITION_FIELD_SIX,
   output var logic [3:0] CONDITION_MASK,
   output var logic CONDITION_WRITE,
   output var logic UNDECODED
);

   // Orderable key: positive above negative, both zeros share one key
   function automatic logic [31:0] fp_key(input logic [31:0] x);
      logic [31:0] k;
      k = VCU_ZERO_KEY;
      if (x[30:0] != 31'h0000_0000) begin
         if (x[31]) begin
            k = ~x;
         end else begin
            k = {1'b1, x[30:0]};
         end
      end
      return k;
   endfunction : fp_key

   function automatic logic fp_is_nan(input logic [31:0] x);
      return (x[30:23] == VCU_EXP_ALL_ONES) && (x[22:0] != 23'h00_0000);
   endfunction : fp_is_nan

   function automatic logic fp_is_denorm(input logic [31:0] x);
      return (x[30:23] == 8'h00) && (x[22:0] != 23'h00_0000);
   endfunction : fp_is_denorm

   logic denormal_flush_control;
   logic last_undecoded;
   vcu_op_type op;
   logic record_bit;
   logic [VCU_LANES-1:0] nan_lane;
   logic [VCU_LANES-1:0] fp_equal;
   logic [VCU_LANES-1:0] fp_ge;
   logic [1:0] bound_code [VCU_LANES];
   logic [VCU_BYTES-1:0] byte_equal;
   logic [VCU_VEC_W-1:0] next_destination;
   logic [3:0] next_condition;
   logic [3:0] next_mask;
   logic [VCU_REG_DATA_W-1:0] next_read_data;

   // Instruction decode
   always_comb begin
      op = VCU_OP_NONE;
      record_bit = INSTRUCTION[VCU_RECORD_POS];
      if (INSTRUCTION[VCU_OPCODE_MSB:VCU_OPCODE_LSB] == VCU_PRIMARY_OPCODE) begin
         case (INSTRUCTION[9:0])
            VCU_XO_BOUNDS: op = VCU_OP_BOUNDS;
            VCU_XO_FP_EQUAL: op = VCU_OP_FP_EQUAL;
            VCU_XO_FP_GE: op = VCU_OP_FP_GE;
            VCU_XO_EQ_BYTE: op = VCU_OP_EQ_BYTE;
            VCU_XO_EQ_HALF: op = VCU_OP_EQ_HALF;
            VCU_XO_EQ_WORD: op = VCU_OP_EQ_WORD;
            default: op = VCU_OP_NONE;
         endcase
      end
   end

   // Word lanes for floating-point compares
   genvar w;
   generate
      for (w = 0; w < VCU_LANES; w++) begin : g_lane
         logic [31:0] a;
         logic [31:0] b;
         logic [31:0] fa;
         logic [31:0] fb;
         logic [31:0] neg_b;
         logic le_b;
         logic ge_neg_b;
         assign a = FIRST_SOURCE_VECTOR[w*VCU_LANE_W +: VCU_LANE_W];
         assign b = SECOND_SOURCE_VECTOR[w*VCU_LANE_W +: VCU_LANE_W];
         // Denormals become signed zero before the bounds test
         assign fa = (denormal_flush_control && fp_is_denorm(a)) ? {a[31], 31'h0000_0000} : a;
         assign fb = (denormal_flush_control && fp_is_denorm(b)) ? {b[31], 31'h0000_0000} : b;
         assign neg_b = {~fb[31], fb[30:0]};
         assign nan_lane[w] = fp_is_nan(a) || fp_is_nan(b);
         assign le_b = fp_key(fa) <= fp_key(fb);
         // A negative bound makes neg_b above fb, so both tests cannot pass
         assign ge_neg_b = fp_key(fa) >= fp_key(neg_b);
         assign bound_code[w] = nan_lane[w] ? 2'b11 : {~le_b, ~ge_neg_b};
         assign fp_equal[w] = !nan_lane[w] && (fp_key(a) == fp_key(b));
         assign fp_ge[w] = !nan_lane[w] && (fp_key(a) >= fp_key(b));
      end
   endgenerate

   // Byte equality, combined into halfwords and words
   genvar y;
   generate
      for (y = 0; y < VCU_BYTES; y++) begin : g_byte
         assign byte_equal[y] = FIRST_SOURCE_VECTOR[y*8 +: 8] == SECOND_SOURCE_VECTOR[y*8 +: 8];
      end
   endgenerate

   // Result vector selection
   always_comb begin
      next_destination = '0;
      case (op)
         VCU_OP_BOUNDS: begin
            for (int i = 0; i < VCU_LANES; i++) begin
               next_destination[i*VCU_LANE_W +: VCU_LANE_W] = {bound_code[i], 30'h0000_0000};
            end
         end
         VCU_OP_FP_EQUAL: begin
            for (int i = 0; i < VCU_LANES; i++) begin
               next_destination[i*VCU_LANE_W +: VCU_LANE_W] = {VCU_LANE_W{fp_equal[i]}};
            end
         end
         VCU_OP_FP_GE: begin
            for (int i = 0; i < VCU_LANES; i++) begin
               next_destination[i*VCU_LANE_W +: VCU_LANE_W] = {VCU_LANE_W{fp_ge[i]}};
            end
         end
         VCU_OP_EQ_BYTE: begin
            for (int i = 0; i < VCU_BYTES; i++) begin
               next_destination[i*8 +: 8] = {8{byte_equal[i]}};
            end
         end
         VCU_OP_EQ_HALF: begin
            for (int i = 0; i < VCU_BYTES/2; i++) begin
               next_destination[i*16 +: 16] = {16{&byte_equal[i*2 +: 2]}};
            end
         end
         VCU_OP_EQ_WORD: begin
            for (int i = 0; i < VCU_LANES; i++) begin
               next_destination[i*32 +: 32] = {32{&byte_equal[i*4 +: 4]}};
            end
         end
         default: next_destination = '0;
      endcase
   end

   // Condition field summary
   always_comb begin
      if (op == VCU_OP_BOUNDS) begin
         next_condition = {2'b00, ~|next_destination, 1'b0};
         next_mask = VCU_CR_MASK_BOUNDS;
      end else begin
         next_condition = {&next_destination, 1'b0, ~|next_destination, 1'b0};
         next_mask = VCU_CR_MASK_FULL;
      end
   end

   // Destination vector register
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         RESULT_VALID <= 1'b0;
         DESTINATION_VECTOR <= '0;
      end else begin
         RESULT_VALID <= ISSUE_VALID && (op != VCU_OP_NONE);
         if (ISSUE_VALID && (op != VCU_OP_NONE)) begin
            DESTINATION_VECTOR <= next_destination;
         end
      end
   end

   // Condition field six, written only by recorded forms
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         CONDITION_FIELD_SIX <= VCU_CR_RESET;
         CONDITION_MASK <= 4'h0;
         CONDITION_WRITE <= 1'b0;
      end else begin
         CONDITION_WRITE <= ISSUE_VALID && (op != VCU_OP_NONE) && record_bit;
         if (ISSUE_VALID && (op != VCU_OP_NONE) && record_bit) begin
            CONDITION_FIELD_SIX <= next_condition;
            CONDITION_MASK <= next_mask;
         end
      end
   end

   // Undecoded issue flag
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         UNDECODED <= 1'b0;
         last_undecoded <= 1'b0;
      end else begin
         UNDECODED <= ISSUE_VALID && (op == VCU_OP_NONE);
         if (ISSUE_VALID) begin
            last_undecoded <= op == VCU_OP_NONE;
         end
      end
   end

   // Control register
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         denormal_flush_control <= VCU_FLUSH_RESET;
      end else if (REG_WRITE && (REG_ADDRESS == VCU_CTRL_OFFSET)) begin
         denormal_flush_control <= REG_WRITE_DATA[VCU_FLUSH_BIT];
      end
   end

   // Read data, valid in the cycle after the read strobe only
   always_comb begin
      next_read_data = '0;
      if (REG_READ) begin
         case (REG_ADDRESS)
            VCU_CTRL_OFFSET: next_read_data[VCU_FLUSH_BIT] = denormal_flush_control;
            VCU_STATUS_OFFSET: begin
               next_read_data[3:0] = CONDITION_FIELD_SIX;
               next_read_data[VCU_STATUS_UNDECODED_BIT] = last_undecoded;
            end
            default: next_read_data = '0;
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         REG_READ_DATA <= '0;
      end else begin
         REG_READ_DATA <= next_read_data;
      end
   end

   // Checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   sequence s_issue(vcu_op_type o);
      ISSUE_VALID && (op == o);
   endsequence

   sequence s_recorded;
      ISSUE_VALID && (op != VCU_OP_NONE) && record_bit;
   endsequence

   a_bounds_nan_code: assert property (
      s_issue(VCU_OP_BOUNDS) ##0 nan_lane[2] |=> DESTINATION_VECTOR[95:94] == 2'b11)
      else $error("bounds NaN lane code not 11");

   a_bounds_low_zero: assert property (
      s_issue(VCU_OP_BOUNDS) |=> (DESTINATION_VECTOR[29:0] == 30'h0000_0000)
         && (DESTINATION_VECTOR[125:96] == 30'h0000_0000) && RESULT_VALID)
      else $error("bounds lane low bits not zero");

   a_bounds_neg_out: assert property (
      s_issue(VCU_OP_BOUNDS) ##0 (SECOND_SOURCE_VECTOR[127] && !nan_lane[3]
         && (SECOND_SOURCE_VECTOR[126:119] != 8'h00)) |=> DESTINATION_VECTOR[127:126] != 2'b00)
      else $error("negative bound reported within");

   a_fpeq_nan_zero: assert property (
      s_issue(VCU_OP_FP_EQUAL) ##0 nan_lane[2] |=> DESTINATION_VECTOR[95:64] == 32'h0000_0000)
      else $error("float equal NaN lane not zero");

   a_fpge_nan_zero: assert property (
      s_issue(VCU_OP_FP_GE) ##0 nan_lane[3] |=> DESTINATION_VECTOR[127:96] == 32'h0000_0000)
      else $error("float ge NaN lane not zero");

   a_fp_zero_equal: assert property (
      s_issue(VCU_OP_FP_EQUAL) ##0 (FIRST_SOURCE_VECTOR[62:32] == 31'h0000_0000)
         && (SECOND_SOURCE_VECTOR[62:32] == 31'h0000_0000)
         |=> DESTINATION_VECTOR[63:32] == 32'hFFFF_FFFF)
      else $error("signed zeros not equal");

   a_cr_hold_norc: assert property (
      !(ISSUE_VALID && (op != VCU_OP_NONE) && record_bit) |=> $stable(CONDITION_FIELD_SIX) && !CONDITION_WRITE)
      else $error("condition field changed without record bit");

   a_bounds_cr_shape: assert property (
      s_issue(VCU_OP_BOUNDS) ##0 record_bit |=> CONDITION_WRITE && (CONDITION_MASK == VCU_CR_MASK_BOUNDS)
         && (CONDITION_FIELD_SIX[3:2] == 2'b00) && !CONDITION_FIELD_SIX[0]
         && (CONDITION_FIELD_SIX[1] == (DESTINATION_VECTOR == '0)))
      else $error("bounds condition field wrong");

   a_summary_cr: assert property (
      s_recorded ##0 (op != VCU_OP_BOUNDS) |=> (CONDITION_FIELD_SIX[3] == (&DESTINATION_VECTOR))
         && (CONDITION_FIELD_SIX[1] == (DESTINATION_VECTOR == '0)) && !CONDITION_FIELD_SIX[2])
      else $error("summary condition field wrong");

   a_byte_equal_lane: assert property (
      s_issue(VCU_OP_EQ_BYTE) |=> DESTINATION_VECTOR[7:0]
         == {8{$past(FIRST_SOURCE_VECTOR[7:0]) == $past(SECOND_SOURCE_VECTOR[7:0])}})
      else $error("byte equal lane wrong");

   a_decode_word_eq: assert property (
      ISSUE_VALID && ((INSTRUCTION & 32'hFFFF_FBFF) == 32'h1000_0086)
         |=> RESULT_VALID && !UNDECODED)
      else $error("word equal pattern not decoded");

endmodule : vcu_compare_unit
`default_nettype wire

// ===== vcu_host_model.sv
// Host issue model: presents instruction words and operand vectors
`timescale 1ns/10ps
`default_nettype none
module vcu_host_model
   import vcu_pkg::*;
(
   input wire logic clock,
   output var logic issue_valid,
   output var logic [31:0] instruction,
   output var logic [VCU_VEC_W-1:0] first_vec,
   output var logic [VCU_VEC_W-1:0] second_vec
);
   initial begin
      issue_valid = 1'b0;
      instruction = 32'h0000_0000;
      first_vec = 128'h0;
      second_vec = 128'h0;
   end
   // Waits idle cycles, holds the request one cycle, then scrambles released lines
   task automatic send(input int idle, input logic [31:0] word,
                       input logic [VCU_VEC_W-1:0] a, input logic [VCU_VEC_W-1:0] b);
      repeat (idle) @(posedge clock);
      @(posedge clock);
      issue_valid <= 1'b1;
      instruction <= word;
      first_vec <= a;
      second_vec <= b;
      @(posedge clock);
      issue_valid <= 1'b0;
      instruction <= ~word;
      first_vec <= ~a;
      second_vec <= ~b;
   endtask : send
endmodule : vcu_host_model
`default_nettype wire

// ===== test_vector_compare_unit.sv
// Testbench for the vector compare unit
`timescale 1ns/10ps
`default_nettype none
module test_vector_compare_unit
   import vcu_pkg::*;
;
   localparam logic [31:0] p1 = 32'h3F80_0000, p2 = 32'h4000_0000, p3 = 32'h4040_0000;
   localparam logic [31:0] nan = 32'h7FC0_0000, sgn = 32'h8000_0000, den = 32'h0000_0001;
   localparam logic [31:0] zr = 32'h0000_0000, on = 32'hFFFF_FFFF, cb = 32'hC000_0000;
   localparam logic [127:0] ia = 128'h0011_2233_4455_6677_8899_AABB_CC80_EEFF;
   localparam logic [127:0] ib = ia ^ 128'h0100_0000_0000_0000_0000_0000_0000_0080;
   logic clk, rst, iv, rv, cw, und, reg_write, reg_read;
   logic [31:0] instr, reg_wdata, rdata, flags;
   logic [127:0] va, vb, dest;
   logic [3:0] reg_addr, cr, mask;
   logic [9:0] xo [3];
   int wd [3];
   int err_total = 0;
   int tests_run = 0;
   assign flags = {21'h0, rv, cw, und, mask, cr};
   vcu_host_model host_u (.clock(clk), .issue_valid(iv), .instruction(instr),
      .first_vec(va), .second_vec(vb));
   vcu_compare_unit dut_u (.CLOCK(clk), .RST(rst), .ISSUE_VALID(iv), .INSTRUCTION(instr),
      .FIRST_SOURCE_VECTOR(va), .SECOND_SOURCE_VECTOR(vb), .REG_ADDRESS(reg_addr),
      .REG_WRITE_DATA(reg_wdata), .REG_WRITE(reg_write), .REG_READ(reg_read),
      .REG_READ_DATA(rdata), .RESULT_VALID(rv), .DESTINATION_VECTOR(dest),
      .CONDITION_FIELD_SIX(cr), .CONDITION_MASK(mask), .CONDITION_WRITE(cw),
      .UNDECODED(und));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [31:0] iw(input logic rec, input logic [9:0] x);
      return {VCU_PRIMARY_OPCODE, 15'h0, rec, x};
   endfunction : iw
   function automatic logic [127:0] emask(input logic [127:0] a, input logic [127:0] b,
                                          input int w);
      logic [127:0] r;
      logic m;
      r = 128'h0;
      for (int e = 0; e < 128; e += w) begin
         m = 1'b0;
         for (int j = e; j < e + w; j++) m |= a[j] ^ b[j];
         for (int j = e; j < e + w; j++) r[j] = ~m;
      end
      return r;
   endfunction : emask
   task automatic chk_vec(input logic [127:0] got, input logic [127:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: vector %h expected %h", $time, got, exp);
      end
   endtask : chk_vec
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: word %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic reg_wr(input logic [3:0] addr, input logic [31:0] data);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= addr;
      reg_wdata <= data;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [3:0] addr, input logic [31:0] exp);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= addr;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      chk_word(rdata, exp);
   endtask : reg_rd
   // Issue, check results one cycle later, then check that pulses dropped
   task automatic run(input logic [31:0] w, input logic [127:0] a, input logic [127:0] b,
                      input logic [127:0] ev, input logic [31:0] ef);
      host_u.send(0, w, a, b);
      @(negedge clk);
      chk_vec(dest, ev);
      chk_word(flags, ef);
      @(negedge clk);
      chk_word(flags & 32'h0000_0700, 32'h0000_0000);
   endtask : run
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      report_and_stop;
   end
   initial begin
      xo = '{VCU_XO_EQ_BYTE, VCU_XO_EQ_HALF, VCU_XO_EQ_WORD};
      wd = '{8, 16, 32};
      rst = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      reg_rd(VCU_CTRL_OFFSET, 32'h0000_0000);
      run(iw(1, VCU_XO_BOUNDS), {zr, nan, p3 ^ sgn, p3}, {p1 ^ sgn, p2, p2, p2},
          {cb, cb, 32'h4000_0000, sgn}, 32'h0000_0620);
      run(iw(0, VCU_XO_BOUNDS), {p2, p2 ^ sgn, p1, den}, {p2, p2, p2, zr},
          {zr, zr, zr, sgn}, 32'h0000_0420);
      reg_wr(VCU_CTRL_OFFSET, 32'h0000_0001);
      reg_rd(VCU_CTRL_OFFSET, 32'h0000_0001);
      reg_wr(4'hC, 32'hFFFF_FFFF);
      reg_rd(4'hC, 32'h0000_0000);
      run(iw(1, VCU_XO_BOUNDS), {p2, p2 ^ sgn, p1, den}, {p2, p2, p2, zr},
          128'h0, 32'h0000_0622);
      reg_rd(VCU_STATUS_OFFSET, 32'h0000_0002);
      run(iw(1, VCU_XO_FP_EQUAL), {p1, nan, zr, p1}, {p2, nan, sgn, p1},
          {zr, zr, on, on}, 32'h0000_06F0);
      run(iw(1, VCU_XO_FP_EQUAL), {4{p1}}, {4{p1}}, {4{on}}, 32'h0000_06F8);
      run(iw(1, VCU_XO_FP_GE), {nan, p1, p1, p2}, {p1, p2, p1, p1},
          {zr, zr, on, on}, 32'h0000_06F0);
      run(iw(1, VCU_XO_FP_GE), {4{p1}}, {4{p2}}, 128'h0, 32'h0000_06F2);
      for (int k = 0; k < 3; k++) begin
         run(iw(1, xo[k]), ia, ib, emask(ia, ib, wd[k]), 32'h0000_06F0);
      end
      host_u.send(2, iw(1, 10'h2C6), ia, ib);
      @(negedge clk);
      chk_word(flags, 32'h0000_01F0);
      chk_vec(dest, emask(ia, ib, 32));
      reg_rd(VCU_STATUS_OFFSET, 32'h0000_0010);
      report_and_stop;
   end
endmodule : test_vector_compare_unit
`default_nettype wire
